/* src/ext_irq_pkg.sv */
// Package with register map, field positions and bus carrier types for the enable/flag block
package ext_irq_pkg;

    // Register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [3:0] ADDR_ENABLE     = 4'h0;
    localparam logic [3:0] ADDR_FLAGS      = 4'h1;
    localparam logic [3:0] ADDR_EVT_STATUS = 4'h2;
    localparam logic [3:0] ADDR_EVT_MASK   = 4'h3;

    // Field positions, shared by enable, flag, event status and event mask; wakeup bit 5 only in enable
    localparam int BIT_DT     = 7;
    localparam int BIT_WAKEUP = 5;
    localparam int BIT_PIN3   = 3;
    localparam int BIT_PIN0   = 0;

    // Fixed bits and writable masks
    localparam logic [7:0] ENABLE_FIXED_ONES = 8'h10;
    localparam logic [7:0] ENABLE_RW_MASK    = 8'hA9;
    localparam logic [7:0] FLAGS_FIXED_ONES  = 8'h30;
    localparam logic [7:0] FLAGS_RW_MASK     = 8'h89;
    localparam logic [7:0] EVT_RW_MASK       = 8'h89;

    // Values after reset, and the read value of unmapped addresses
    localparam logic [7:0] EVT_STATUS_RESET = 8'h00;
    localparam logic [7:0] EVT_MASK_RESET   = 8'h00;
    localparam logic [7:0] RDATA_RESET      = 8'h00;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // One register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // Interrupt requests towards the core
    typedef struct packed {
        logic direct_transition;
        logic wakeup;
        logic pin3;
        logic pin0;
    } src_req_t;

endpackage : ext_irq_pkg

/* src/ext_pin_irq_enable_flags.sv */
// Enable and request-flag registers for direct-transition, pin 3, pin 0 and wakeup sources
//
// Function
// [RL1] Enable bit 7 gates direct-transition requests; resets 0, read/write.
// [RL2] Enable bit 5 is one shared enable for all six wakeup pins; resets 0.
// [RL3] Enable bit 3 gates pin 3 requests; resets 0, read/write.
// [RL4] Enable bit 0 gates pin 0 requests; resets 0, read/write.
// [RL5] Enable bit 4 reads 1, bits 6, 2, 1 read 0; writes ignored.
// [RL6] Software clears enables or flags only while the core mask bit is set.
// [RL7] Clear colliding with a new request still yields that interrupt afterwards; a wakeup request colliding with a bit 5 clear is dropped.
// [RL8] Flag bit 7 sets on a direct transfer while direct transfer is on.
// [RL9] Direct-transition flag clears on writing 0; resets 0.
// [RL10] Flag bits 5, 4 read 1, bits 6, 2, 1 read 0.
// [RL11] Flag bit 3 sets on the selected edge of pin 3 in interrupt mode.
// [RL12] Pin 3 flag clears on writing 0; resets 0.
// [RL13] Flag bit 0 sets on the selected edge of pin 0 in interrupt mode.
// [RL14] Pin 0 flag clears on writing 0; resets 0.
// [RL15] Edge select 0 detects falling edges, 1 detects rising edges.
// [RL16] Request to the core is the flag ANDed with its enable.
// [RL17] Writing 1 to a flag keeps it; a set beats a same-cycle clear.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps

module ext_pin_irq_enable_flags
    import ext_irq_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    // Register bus
    input  wire reg_req_t   bus,
    output logic [7:0]      rdata,
    // External interrupt pins and their configuration
    input  wire logic       ext_irq_pin3,
    input  wire logic       ext_irq_pin0,
    input  wire logic       pin3_is_irq,
    input  wire logic       pin0_is_irq,
    input  wire logic       pin3_edge_select,
    input  wire logic       pin0_edge_select,
    // Direct transfer from the sleep logic
    input  wire logic       direct_transfer_event,
    input  wire logic       direct_transfer_on,
    // Wakeup flags from the neighbouring flag register
    input  wire logic [5:0] wakeup_flags,
    // Requests to the core and enable to the wakeup logic
    output src_req_t        reqs,
    output logic            wakeup_irq_en,
    output logic            irq
);

    // Edge hit for a pin, polarity chosen by its select bit
    function automatic logic edge_hit(input logic now, input logic prev,
                                      input logic rising_sel);
        return rising_sel ? (now & ~prev) : (~now & prev);
    endfunction : edge_hit

    // Next value of a request flag; a set event beats a clearing write
    function automatic logic next_flag(input logic flag, input logic set_evt,
                                       input logic wr, input logic wbit);
        return set_evt | (flag & ~(wr & ~wbit));
    endfunction : next_flag

    // Enable bits
    logic direct_transition_irq_en;
    logic pin3_irq_en;
    logic pin0_irq_en;
    logic wakeup_en_q;

    // Request flags and late requests caught on an enable clear
    logic direct_transition_req_flag;
    logic pin3_req_flag;
    logic pin0_req_flag;
    logic pend_dt;
    logic pend_p3;
    logic pend_p0;

    // Event status for the summary interrupt
    logic [7:0] evt_status;
    logic [7:0] evt_mask;

    // Pin history for edge detection
    logic       prev_pin3;
    logic       prev_pin0;
    logic       edges_armed;

    // Decoded strobes
    logic       wr_enable;
    logic       wr_flags;
    logic       wr_status;
    logic       wr_mask;

    // Set events
    logic       set_dt;
    logic       set_p3;
    logic       set_p0;
    logic [7:0] set_vec;

    // Next values
    logic       next_en_dt;
    logic       next_en_p3;
    logic       next_en_p0;
    logic       next_en_wp;
    logic       next_flag_dt;
    logic       next_flag_p3;
    logic       next_flag_p0;
    logic       next_pend_dt;
    logic       next_pend_p3;
    logic       next_pend_p0;
    logic [7:0] next_status;
    logic [7:0] next_mask;

    // Address decode of the write strobe
    assign wr_enable = bus.wr && (bus.addr == ADDR_ENABLE);
    assign wr_flags  = bus.wr && (bus.addr == ADDR_FLAGS);
    assign wr_status = bus.wr && (bus.addr == ADDR_EVT_STATUS);
    assign wr_mask   = bus.wr && (bus.addr == ADDR_EVT_MASK);

    // Edge events; the first cycle after reset is skipped so a high pin is no edge
    assign set_p3 = pin3_is_irq && edges_armed
                    && edge_hit(ext_irq_pin3, prev_pin3, pin3_edge_select); // RL11 RL15
    assign set_p0 = pin0_is_irq && edges_armed
                    && edge_hit(ext_irq_pin0, prev_pin0, pin0_edge_select); // RL13 RL15
    assign set_dt = direct_transfer_event && direct_transfer_on; // RL8

    // Same layout as the flag register
    always_comb begin
        set_vec           = 8'h00;
        set_vec[BIT_DT]   = set_dt;
        set_vec[BIT_PIN3] = set_p3;
        set_vec[BIT_PIN0] = set_p0;
    end

    // Enables take only their own bits; fixed bits never stored
    assign next_en_dt = wr_enable ? bus.wdata[BIT_DT]     : direct_transition_irq_en; // RL1 RL5
    assign next_en_wp = wr_enable ? bus.wdata[BIT_WAKEUP] : wakeup_en_q;              // RL2
    assign next_en_p3 = wr_enable ? bus.wdata[BIT_PIN3]   : pin3_irq_en;              // RL3
    assign next_en_p0 = wr_enable ? bus.wdata[BIT_PIN0]   : pin0_irq_en;              // RL4

    // Flags clear on a written 0, keep on a written 1
    assign next_flag_dt = next_flag(direct_transition_req_flag, set_dt,
                                    wr_flags, bus.wdata[BIT_DT]);   // RL9 RL17
    assign next_flag_p3 = next_flag(pin3_req_flag, set_p3,
                                    wr_flags, bus.wdata[BIT_PIN3]); // RL12 RL17
    assign next_flag_p0 = next_flag(pin0_req_flag, set_p0,
                                    wr_flags, bus.wdata[BIT_PIN0]); // RL14 RL17

    // An enable cleared in the cycle its source fires keeps that one request
    // alive until the flag is cleared. Software normally avoids this by masking
    // at the core first; this covers the unmasked race.
    assign next_pend_dt = (pend_dt | (set_dt & direct_transition_irq_en & ~next_en_dt))
                          & next_flag_dt; // RL7 RL6
    assign next_pend_p3 = (pend_p3 | (set_p3 & pin3_irq_en & ~next_en_p3))
                          & next_flag_p3; // RL7
    assign next_pend_p0 = (pend_p0 | (set_p0 & pin0_irq_en & ~next_en_p0))
                          & next_flag_p0; // RL7

    // Event status: write one to clear, a new event wins
    assign next_status = ((evt_status & ~(wr_status ? bus.wdata : 8'h00)) | set_vec)
                         & EVT_RW_MASK;
    assign next_mask   = wr_mask ? (bus.wdata & EVT_RW_MASK) : evt_mask;

    // Enable register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            direct_transition_irq_en <= 1'b0;
            wakeup_en_q              <= 1'b0;
            pin3_irq_en              <= 1'b0;
            pin0_irq_en              <= 1'b0;
        end else begin
            direct_transition_irq_en <= next_en_dt;
            wakeup_en_q              <= next_en_wp;
            pin3_irq_en              <= next_en_p3;
            pin0_irq_en              <= next_en_p0;
        end
    end

    // Request flags and late-request holders
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            direct_transition_req_flag <= 1'b0;
            pin3_req_flag              <= 1'b0;
            pin0_req_flag              <= 1'b0;
            pend_dt                    <= 1'b0;
            pend_p3                    <= 1'b0;
            pend_p0                    <= 1'b0;
        end else begin
            direct_transition_req_flag <= next_flag_dt;
            pin3_req_flag              <= next_flag_p3;
            pin0_req_flag              <= next_flag_p0;
            pend_dt                    <= next_pend_dt;
            pend_p3                    <= next_pend_p3;
            pend_p0                    <= next_pend_p0;
        end
    end

    // Pin history; armed one cycle after reset release
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prev_pin3   <= 1'b0;
            prev_pin0   <= 1'b0;
            edges_armed <= 1'b0;
        end else begin
            prev_pin3   <= ext_irq_pin3;
            prev_pin0   <= ext_irq_pin0;
            edges_armed <= 1'b1;
        end
    end

    // Requests to the core, registered from next state so they track the flags
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reqs          <= '0;
            wakeup_irq_en <= 1'b0;
        end else begin
            reqs.direct_transition <= next_flag_dt & (next_en_dt | next_pend_dt); // RL16 RL1
            reqs.pin3              <= next_flag_p3 & (next_en_p3 | next_pend_p3); // RL16 RL3
            reqs.pin0              <= next_flag_p0 & (next_en_p0 | next_pend_p0); // RL16 RL4
            reqs.wakeup            <= (|wakeup_flags) & next_en_wp;               // RL2
            wakeup_irq_en          <= next_en_wp;                                 // RL2
        end
    end

    // Event status, mask and summary interrupt
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            evt_status <= EVT_STATUS_RESET;
            evt_mask   <= EVT_MASK_RESET;
            irq        <= 1'b0;
        end else begin
            evt_status <= next_status;
            evt_mask   <= next_mask;
            irq        <= |(next_status & next_mask);
        end
    end

    // Read data one cycle after the strobe; reads have no side effect
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= RDATA_RESET;
        end else if (bus.rd) begin
            case (bus.addr)
                ADDR_ENABLE: begin
                    rdata <= ENABLE_FIXED_ONES
                             | {direct_transition_irq_en, 1'b0, wakeup_en_q, 1'b0,
                                pin3_irq_en, 2'b00, pin0_irq_en}; // RL5
                end
                ADDR_FLAGS: begin
                    rdata <= FLAGS_FIXED_ONES
                             | {direct_transition_req_flag, 3'b000, pin3_req_flag,
                                2'b00, pin0_req_flag}; // RL10
                end
                ADDR_EVT_STATUS: begin
                    rdata <= evt_status;
                end
                ADDR_EVT_MASK: begin
                    rdata <= evt_mask;
                end
                default: begin
                    rdata <= UNMAPPED_READ;
                end
            endcase
        end else begin
            rdata <= RDATA_RESET;
        end
    end

    // Checks on the behaviour above
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_dt_flag_set: assert property ( // RL8
        set_dt |=> direct_transition_req_flag
    ) else $error("direct transfer did not set its flag");

    a_pin3_flag_set: assert property ( // RL11
        set_p3 |=> pin3_req_flag
    ) else $error("pin 3 edge did not set its flag");

    a_pin0_falling_edge: assert property ( // RL15
        (pin0_is_irq && edges_armed && !pin0_edge_select && $fell(ext_irq_pin0))
        |=> pin0_req_flag
    ) else $error("falling edge on pin 0 not caught");

    a_pin0_zero_clear: assert property ( // RL14
        (wr_flags && !bus.wdata[BIT_PIN0] && !set_p0) |=> !pin0_req_flag
    ) else $error("pin 0 flag not cleared by a written 0");

    a_flag_one_keeps: assert property ( // RL17
        (wr_flags && bus.wdata[BIT_PIN3] && pin3_req_flag) |=> pin3_req_flag
    ) else $error("writing 1 altered the pin 3 flag");

    a_enable_fixed_bits: assert property ( // RL5
        (bus.rd && bus.addr == ADDR_ENABLE)
        |=> ((rdata & ~ENABLE_RW_MASK) == ENABLE_FIXED_ONES)
    ) else $error("enable register fixed bits read wrong");

    a_flags_fixed_bits: assert property ( // RL10
        (bus.rd && bus.addr == ADDR_FLAGS)
        |=> ((rdata & ~FLAGS_RW_MASK) == FLAGS_FIXED_ONES)
    ) else $error("flag register fixed bits read wrong");

    a_pin3_req_gate: assert property ( // RL16
        (set_p3 && pin3_irq_en && !wr_enable) |=> reqs.pin3 ##0 pin3_req_flag
    ) else $error("enabled pin 3 flag gave no request");

    a_clear_race_kept: assert property ( // RL7
        (set_p0 && pin0_irq_en && wr_enable && !bus.wdata[BIT_PIN0])
        |=> reqs.pin0 && !pin0_irq_en
    ) else $error("request lost on colliding enable clear");

    a_dt_req_gated: assert property ( // RL1
        reqs.direct_transition |-> (direct_transition_irq_en || pend_dt)
    ) else $error("direct transition request without enable");

    a_wakeup_gate: assert property ( // RL2
        $rose(reqs.wakeup) |-> wakeup_irq_en && ($past(wakeup_flags) != 6'h00)
    ) else $error("wakeup request without enable or flag");

    a_irq_summary: assert property (
        irq == (|(evt_status & evt_mask))
    ) else $error("summary interrupt differs from unmasked status");

    a_dt_zero_clear: assert property ( // RL9
        (wr_flags && !bus.wdata[BIT_DT] && !set_dt) |=> !direct_transition_req_flag
    ) else $error("direct transition flag not cleared by a written 0");

    a_pin3_zero_clear: assert property ( // RL12
        (wr_flags && !bus.wdata[BIT_PIN3] && !set_p3) |=> !pin3_req_flag
    ) else $error("pin 3 flag not cleared by a written 0");

    a_pin3_rising_edge: assert property ( // RL15
        (pin3_is_irq && edges_armed && pin3_edge_select && $rose(ext_irq_pin3))
        |=> pin3_req_flag
    ) else $error("rising edge on pin 3 not caught");

    a_dt_off_refused: assert property ( // RL8
        (!direct_transfer_on && !direct_transition_req_flag && !set_dt)
        |=> !direct_transition_req_flag
    ) else $error("direct transition flag set while direct transfer off");

    // Read data must not linger, or software would see stale values
    a_rdata_idle_zero: assert property (
        !bus.rd |=> (rdata == RDATA_RESET)
    ) else $error("read data not idle after a cycle without read");

    // Main scenarios
    c_race_seen: cover property (
        set_p0 && pin0_irq_en && wr_enable && !bus.wdata[BIT_PIN0]);
    c_dt_request: cover property (set_dt && direct_transition_irq_en ##1 reqs.direct_transition);
    c_irq_cleared: cover property (irq ##1 wr_status ##1 !irq);
    c_rising_pin3: cover property (set_p3 && pin3_edge_select);

endmodule : ext_pin_irq_enable_flags

/* verif/ext_irq_partner.sv */
// Model of the interrupt pins and of the sleep logic that feed the block
`timescale 1ns/10ps

module ext_irq_partner (
    // Clock
    input  wire logic       sys_clk,
    // Pin levels {pin 3, pin 0} and the direct transfer pulse
    output logic [1:0]      pins,
    output logic            dt_event
);
    // Pins rest high, as an undriven pad with a pull-up would
    initial begin
        pins     = 2'h3;
        dt_event = 1'b0;
    end

    // Preset the start level first, so that no stray edge is made when already there
    task automatic pin_edge(input logic sel3, input logic rising);
        repeat (2) @(posedge sys_clk);
        pins[sel3] <= !rising;
        repeat (2) @(posedge sys_clk);
        pins[sel3] <= rising;
    endtask : pin_edge

    // Sleep causing a direct transfer: one cycle pulse
    task automatic dt_pulse();
        @(posedge sys_clk);
        dt_event <= 1'b1;
        @(posedge sys_clk);
        dt_event <= 1'b0;
    endtask : dt_pulse
endmodule : ext_irq_partner

/* verif/ext_pin_irq_enable_flags_tb.sv */
// Self-checking bench for the enable and request-flag block
`timescale 1ns/10ps

module ext_pin_irq_enable_flags_tb
    import ext_irq_pkg::*;
;
    logic       sys_clk;
    logic       rstn;
    reg_req_t   bus;
    logic [7:0] rdata;
    logic [1:0] pins;
    logic       dt_event;
    logic       is_irq;
    logic       edge_sel;
    logic       dt_on;
    logic [5:0] wakeup_flags;
    src_req_t   reqs;
    logic       wakeup_irq_en;
    logic       irq;
    int         err_total = 0;
    int         n_checks  = 0;

    ext_pin_irq_enable_flags i_ext_pin_irq_enable_flags (
        .sys_clk(sys_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
        .ext_irq_pin3(pins[1]), .ext_irq_pin0(pins[0]),
        .pin3_is_irq(is_irq), .pin0_is_irq(is_irq),
        .pin3_edge_select(edge_sel), .pin0_edge_select(edge_sel),
        .direct_transfer_event(dt_event), .direct_transfer_on(dt_on),
        .wakeup_flags(wakeup_flags), .reqs(reqs), .wakeup_irq_en(wakeup_irq_en), .irq(irq)
    );

    ext_irq_partner i_ext_irq_partner (.sys_clk(sys_clk), .pins(pins), .dt_event(dt_event));

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Value compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        bus.addr  <= addr;
        bus.wdata <= data;
        bus.wr    <= 1'b1;
        @(posedge sys_clk);
        bus.wr    <= 1'b0;
    endtask : write_reg

    // Read compare; data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [3:0] addr, input logic [7:0] exp);
        @(posedge sys_clk);
        bus.addr <= addr;
        bus.rd   <= 1'b1;
        @(posedge sys_clk);
        bus.rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : chk_reg

    // Reset values, ignored writes of ones and an unmapped address
    task automatic test_reset();
        chk_reg(ADDR_ENABLE, 8'h10);
        chk_reg(ADDR_FLAGS, 8'h30);
        @(posedge sys_clk);
        #1;
        chk(rdata, 8'h00);
        chk({4'h0, reqs}, 8'h00);
        write_reg(ADDR_FLAGS, 8'hFF);
        chk_reg(ADDR_FLAGS, 8'h30);
        write_reg(4'hF, 8'hFF);
        chk_reg(4'hF, 8'h00);
    endtask : test_reset

    // Enable bits, reserved bits and the shared wakeup enable
    task automatic test_enable();
        write_reg(ADDR_ENABLE, 8'hFF);
        wakeup_flags <= 6'h20;
        chk_reg(ADDR_ENABLE, 8'hB9);
        chk({7'h0, wakeup_irq_en}, 8'h01);
        chk({4'h0, reqs}, 8'h04);
        write_reg(ADDR_ENABLE, 8'h56);
        chk_reg(ADDR_ENABLE, 8'h10);
        chk({7'h0, wakeup_irq_en}, 8'h00);
        chk({4'h0, reqs}, 8'h00);
        wakeup_flags <= 6'h00;
    endtask : test_enable

    // Both edge senses on both pins, then with the pins not in interrupt mode
    task automatic test_pins();
        logic rising;
        logic exp;
        write_reg(ADDR_ENABLE, 8'h09);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 6; k++) begin
                rising = k[0];
                exp = (k < 4) && (rising == (k < 2));
                is_irq   <= (k < 4);
                edge_sel <= (k < 2);
                i_ext_irq_partner.pin_edge(p[0], rising);
                repeat (3) @(posedge sys_clk);
                #1;
                chk({4'h0, reqs}, exp ? (p == 1 ? 8'h02 : 8'h01) : 8'h00);
                write_reg(ADDR_FLAGS, 8'hFF);
                chk_reg(ADDR_FLAGS, exp ? (p == 1 ? 8'h38 : 8'h31) : 8'h30);
                write_reg(ADDR_FLAGS, 8'h00);
            end
        end
        chk_reg(ADDR_FLAGS, 8'h30);
        // Pin 0 falls in the very cycle its enable is cleared
        @(posedge sys_clk);
        is_irq <= 1'b1;
        fork
            i_ext_irq_partner.pin_edge(1'b0, 1'b0);
            begin
                repeat (3) @(posedge sys_clk);
                write_reg(ADDR_ENABLE, 8'h08);
            end
        join
        chk_reg(ADDR_ENABLE, 8'h18);
        chk({4'h0, reqs}, 8'h01);
        write_reg(ADDR_FLAGS, 8'h00);
        chk_reg(ADDR_FLAGS, 8'h30);
        chk({4'h0, reqs}, 8'h00);
    endtask : test_pins

    // Event status, mask and the level interrupt
    task automatic test_irq();
        chk_reg(ADDR_EVT_STATUS, 8'h09);
        chk({7'h0, irq}, 8'h00);
        write_reg(ADDR_EVT_MASK, 8'h08);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({7'h0, irq}, 8'h01);
        write_reg(ADDR_EVT_STATUS, 8'h08);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({7'h0, irq}, 8'h00);
        chk_reg(ADDR_EVT_STATUS, 8'h01);
        write_reg(ADDR_EVT_STATUS, 8'h01);
        write_reg(ADDR_EVT_MASK, 8'h00);
    endtask : test_irq

    // Direct transfer flag and clears that collide with a new request
    task automatic test_dt();
        dt_on <= 1'b0;
        i_ext_irq_partner.dt_pulse();
        chk_reg(ADDR_FLAGS, 8'h30);
        dt_on <= 1'b1;
        i_ext_irq_partner.dt_pulse();
        chk_reg(ADDR_FLAGS, 8'hB0);
        chk({4'h0, reqs}, 8'h00);
        write_reg(ADDR_ENABLE, 8'h89);
        chk_reg(ADDR_ENABLE, 8'h99);
        chk({4'h0, reqs}, 8'h08);
        write_reg(ADDR_FLAGS, 8'h00);
        chk_reg(ADDR_FLAGS, 8'h30);
        // Clears with the core unmasked, on purpose
        fork
            write_reg(ADDR_ENABLE, 8'h09);
            i_ext_irq_partner.dt_pulse();
        join
        repeat (2) @(posedge sys_clk);
        #1;
        chk({4'h0, reqs}, 8'h08);
        write_reg(ADDR_FLAGS, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({4'h0, reqs}, 8'h00);
        fork
            write_reg(ADDR_FLAGS, 8'h00);
            i_ext_irq_partner.dt_pulse();
        join
        chk_reg(ADDR_FLAGS, 8'hB0);
    endtask : test_dt

    // Counts and verdict
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        close_out();
    end

    // Main sequence
    initial begin
        rstn         = 1'b0;
        bus          = '0;
        is_irq       = 1'b0;
        edge_sel     = 1'b0;
        dt_on        = 1'b0;
        wakeup_flags = 6'h00;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        test_reset();
        test_enable();
        test_pins();
        test_irq();
        test_dt();
        close_out();
    end
endmodule : ext_pin_irq_enable_flags_tb
